// ==== design/crcfs_engine.sv ====
`timescale 1ns/1ns
`default_nettype none

module crcfs_engine (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // special-function-register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata_q,
   // internal flash read port
   output logic [crcfs_pkg::FLASH_AW-1:0] flash_addr_q,
   output logic flash_rd_q,
   input wire logic [7:0] flash_rdata,
   // core stall
   output logic cpu_stall_q
);

   ////////////////////////////////////////////////////////////////////////////
   // helper functions

   // fold one byte into the running crc, msb first
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
                                            input logic sel);
      logic [31:0] r;
      logic [15:0] h;
      r = c ^ {d, 24'h00_0000};
      h = c[15:0] ^ {d, 8'h00};
      for (int i = 0; i < 8; i++)
      begin
         r = r[31] ? ({r[30:0], 1'b0} ^ crcfs_pkg::POLY32) : {r[30:0], 1'b0};
         h = h[15] ? ({h[14:0], 1'b0} ^ crcfs_pkg::POLY16) : {h[14:0], 1'b0};
      end
      return sel ? {16'h0000, h} : r;
   endfunction : crc_byte

   // result byte index chosen by pointer and mode
   function automatic logic [1:0] byte_index(input logic [1:0] p, input logic sel);
      return sel ? {1'b0, p[0]} : p;
   endfunction : byte_index

   // read the pointed result byte
   function automatic logic [7:0] get_byte(input logic [31:0] c, input logic [1:0] p,
                                           input logic sel);
      logic [1:0] k;
      k = byte_index(p, sel);
      return c[8*k +: 8];
   endfunction : get_byte

   // bit reversal of a byte
   function automatic logic [7:0] flip_byte(input logic [7:0] b);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
      begin
         r[i] = b[7-i];
      end
      return r;
   endfunction : flip_byte

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [31:0] crc_q, crc_d;
   crcfs_pkg::crcfs_ctrl_t ctrl_q, ctrl_d;
   crcfs_pkg::crcfs_auto_t auto_q, auto_d;
   logic [5:0] count_q, count_d;
   logic [7:0] data_in_q, data_in_d;
   logic [7:0] flip_q, flip_d;
   logic [7:0] sfr_rdata_d;
   crcfs_pkg::crcfs_scan_t scan_q, scan_d;
   logic [crcfs_pkg::FLASH_AW-1:0] flash_addr_d, last_addr_q, last_addr_d;
   logic flash_rd_d;
   logic cpu_stall_d;

   // decoded strobes, ignored while the core is stalled
   logic busy;
   logic wr_ctl, wr_res, rd_res, wr_din, wr_flip, wr_auto, wr_cnt;
   logic [6:0] last_sector;

   assign busy = (scan_q != crcfs_pkg::SCAN_IDLE);
   assign wr_ctl = sfr_wr && !busy && (sfr_addr == crcfs_pkg::ADDR_CONTROL);
   assign wr_res = sfr_wr && !busy && (sfr_addr == crcfs_pkg::ADDR_RESULT);
   assign rd_res = sfr_rd && !busy && (sfr_addr == crcfs_pkg::ADDR_RESULT);
   assign wr_din = sfr_wr && !busy && (sfr_addr == crcfs_pkg::ADDR_DATA_IN);
   assign wr_flip = sfr_wr && !busy && (sfr_addr == crcfs_pkg::ADDR_FLIP);
   assign wr_auto = sfr_wr && !busy && (sfr_addr == crcfs_pkg::ADDR_AUTO);
   assign wr_cnt = sfr_wr && !busy && (sfr_addr == crcfs_pkg::ADDR_COUNT);
   assign last_sector = {1'b0, auto_q.start_sector} + {1'b0, count_q};

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic for registers, result and scan sequencer
   always_comb
   begin
      crc_d = crc_q;
      ctrl_d = ctrl_q;
      auto_d = auto_q;
      count_d = count_q;
      data_in_d = data_in_q;
      flip_d = flip_q;
      sfr_rdata_d = sfr_rdata_q;
      scan_d = scan_q;
      flash_addr_d = flash_addr_q;
      last_addr_d = last_addr_q;
      flash_rd_d = 1'b0;
      // register reads, one cycle latency, unmapped reads zero
      if (sfr_rd && !busy)
      begin
         case (sfr_addr)
            crcfs_pkg::ADDR_RESULT: sfr_rdata_d = get_byte(crc_q, ctrl_q.ptr,
                                                           ctrl_q.poly_sel);
            crcfs_pkg::ADDR_CONTROL: sfr_rdata_d = {3'b000, ctrl_q.poly_sel, 1'b0,
                                                   ctrl_q.preset_val, ctrl_q.ptr};
            crcfs_pkg::ADDR_DATA_IN: sfr_rdata_d = data_in_q;
            crcfs_pkg::ADDR_FLIP: sfr_rdata_d = flip_byte(flip_q);
            crcfs_pkg::ADDR_AUTO: sfr_rdata_d = auto_q;
            crcfs_pkg::ADDR_COUNT: sfr_rdata_d = {2'b00, count_q};
            default: sfr_rdata_d = 8'h00;
         endcase
      end
      // control write: mode, preset, pointer, optional init and launch
      if (wr_ctl)
      begin
         ctrl_d.poly_sel = sfr_wdata[crcfs_pkg::CTL_POLY_BIT];
         ctrl_d.preset_val = sfr_wdata[crcfs_pkg::CTL_PRESET_BIT];
         ctrl_d.ptr = sfr_wdata[crcfs_pkg::CTL_PTR_LSB +: 2];
         if (sfr_wdata[crcfs_pkg::CTL_INIT_BIT])
         begin
            crc_d = sfr_wdata[crcfs_pkg::CTL_PRESET_BIT] ? crcfs_pkg::PRESET_ONES
                                                         : crcfs_pkg::PRESET_ZEROS;
         end
         if (auto_q.enable)
         begin
            scan_d = crcfs_pkg::SCAN_REQ;
            flash_addr_d = {1'b0, auto_q.start_sector, crcfs_pkg::SECTOR_FIRST_OFS};
            last_addr_d = {last_sector, crcfs_pkg::SECTOR_LAST_OFS};
            flash_rd_d = 1'b1;
         end
      end
      // result port access moves the pointer
      if (wr_res)
      begin
         crc_d[8*byte_index(ctrl_q.ptr, ctrl_q.poly_sel) +: 8] = sfr_wdata;
      end
      if (wr_res || rd_res)
      begin
         ctrl_d.ptr = ctrl_q.ptr + 2'b01;
      end
      // data input folds a byte
      if (wr_din)
      begin
         data_in_d = sfr_wdata;
         crc_d = crc_byte(crc_q, sfr_wdata, ctrl_q.poly_sel);
      end
      if (wr_flip)
      begin
         flip_d = sfr_wdata;
      end
      // done bit is not writable
      if (wr_auto)
      begin
         auto_d.enable = sfr_wdata[crcfs_pkg::AUTO_EN_BIT];
         auto_d.start_sector = sfr_wdata[crcfs_pkg::AUTO_ST_LSB +: 6];
      end
      if (wr_cnt)
      begin
         count_d = sfr_wdata[5:0];
      end
      // scan sequencer: request byte, then fold it
      case (scan_q)
         crcfs_pkg::SCAN_IDLE: ;
         crcfs_pkg::SCAN_REQ: scan_d = crcfs_pkg::SCAN_FOLD;
         crcfs_pkg::SCAN_FOLD:
         begin
            crc_d = crc_byte(crc_q, flash_rdata, ctrl_q.poly_sel);
            if (flash_addr_q == last_addr_q)
            begin
               scan_d = crcfs_pkg::SCAN_IDLE;
            end
            else
            begin
               scan_d = crcfs_pkg::SCAN_REQ;
               flash_addr_d = flash_addr_q + 17'h0_0001;
               flash_rd_d = 1'b1;
            end
         end
         default: scan_d = crcfs_pkg::SCAN_IDLE;
      endcase
      auto_d.done = (scan_d == crcfs_pkg::SCAN_IDLE);
   end

   // stall follows the sequencer one for one
   assign cpu_stall_d = (scan_d != crcfs_pkg::SCAN_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         crc_q <= crcfs_pkg::RST_RESULT;
         ctrl_q <= crcfs_pkg::crcfs_ctrl_t'(crcfs_pkg::RST_CONTROL[3:0]);
         auto_q <= crcfs_pkg::RST_AUTO;
         count_q <= crcfs_pkg::RST_COUNT[5:0];
         data_in_q <= crcfs_pkg::RST_DATA_IN;
         flip_q <= crcfs_pkg::RST_FLIP;
         sfr_rdata_q <= 8'h00;
         scan_q <= crcfs_pkg::SCAN_IDLE;
         flash_addr_q <= 17'h0_0000;
         last_addr_q <= 17'h0_0000;
         flash_rd_q <= 1'b0;
         cpu_stall_q <= 1'b0;
      end
      else
      begin
         crc_q <= crc_d;
         ctrl_q <= ctrl_d;
         auto_q <= auto_d;
         count_q <= count_d;
         data_in_q <= data_in_d;
         flip_q <= flip_d;
         sfr_rdata_q <= sfr_rdata_d;
         scan_q <= scan_d;
         flash_addr_q <= flash_addr_d;
         last_addr_q <= last_addr_d;
         flash_rd_q <= flash_rd_d;
         cpu_stall_q <= cpu_stall_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   sequence seq_byte_req;
      flash_rd_q && (scan_q == crcfs_pkg::SCAN_REQ);
   endsequence

   sequence seq_byte_fold;
      scan_q == crcfs_pkg::SCAN_FOLD;
   endsequence

   chk_init_preset: assert property (wr_ctl && sfr_wdata[crcfs_pkg::CTL_INIT_BIT]
      |=> crc_q == ($past(sfr_wdata[crcfs_pkg::CTL_PRESET_BIT]) ? 32'hffff_ffff : 32'h0000_0000))
      else $error("init did not preset the result");

   chk_ptr_step: assert property ((wr_res || rd_res) |=> ctrl_q.ptr == $past(ctrl_q.ptr) + 2'b01)
      else $error("result pointer did not advance");

   chk_result_read: assert property (rd_res
      |=> sfr_rdata_q == get_byte($past(crc_q), $past(ctrl_q.ptr), $past(ctrl_q.poly_sel)))
      else $error("result port read wrong byte");

   chk_data_fold: assert property (wr_din
      |=> crc_q == crc_byte($past(crc_q), $past(sfr_wdata), $past(ctrl_q.poly_sel)))
      else $error("data input byte not folded");

   chk_scan_start: assert property (wr_ctl && auto_q.enable
      |=> seq_byte_req ##0 flash_addr_q == {1'b0, $past(auto_q.start_sector), 10'h000})
      else $error("scan did not start at first sector");

   chk_scan_step: assert property (seq_byte_req |=> seq_byte_fold)
      else $error("requested byte not folded next cycle");

   chk_scan_fold: assert property (seq_byte_fold
      |=> crc_q == crc_byte($past(crc_q), $past(flash_rdata), ctrl_q.poly_sel))
      else $error("flash byte not folded");

   chk_scan_end: assert property (seq_byte_fold ##0 (flash_addr_q[9:0] == 10'h3ff
      && flash_addr_q[16:10] == last_sector) |=> scan_q == crcfs_pkg::SCAN_IDLE && !cpu_stall_q)
      else $error("scan did not end after last sector");

   chk_done_flag: assert property (auto_q.done == !busy)
      else $error("done flag disagrees with scan state");

   chk_stall_scan: assert property (cpu_stall_q == busy)
      else $error("stall does not cover the scan");

   chk_count_upper: assert property (sfr_rd && sfr_addr == crcfs_pkg::ADDR_COUNT && !busy
      |=> sfr_rdata_q[7:6] == 2'b00)
      else $error("sector count upper bits not zero");

   chk_flip_read: assert property (sfr_rd && sfr_addr == crcfs_pkg::ADDR_FLIP && !busy
      |=> {sfr_rdata_q[0], sfr_rdata_q[1], sfr_rdata_q[2], sfr_rdata_q[3], sfr_rdata_q[4],
      sfr_rdata_q[5], sfr_rdata_q[6], sfr_rdata_q[7]} == $past(flip_q))
      else $error("flip register not reversed");

endmodule : crcfs_engine

`default_nettype wire

// ==== design/crcfs_pkg.sv ====
package crcfs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register addresses on the special-function-register bus
   localparam logic [7:0] ADDR_RESULT = 8'h91;
   localparam logic [7:0] ADDR_CONTROL = 8'h92;
   localparam logic [7:0] ADDR_DATA_IN = 8'h93;
   localparam logic [7:0] ADDR_FLIP = 8'h95;
   localparam logic [7:0] ADDR_AUTO = 8'h96;
   localparam logic [7:0] ADDR_COUNT = 8'h97;

   ////////////////////////////////////////////////////////////////////////////
   // control register field positions
   localparam int CTL_POLY_BIT = 4;
   localparam int CTL_INIT_BIT = 3;
   localparam int CTL_PRESET_BIT = 2;
   localparam int CTL_PTR_LSB = 0;

   // automatic control register field positions
   localparam int AUTO_EN_BIT = 7;
   localparam int AUTO_DONE_BIT = 6;
   localparam int AUTO_ST_LSB = 0;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_AUTO = 8'h40;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_DATA_IN = 8'h00;
   localparam logic [7:0] RST_FLIP = 8'h00;
   localparam logic [31:0] RST_RESULT = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // crc constants
   localparam logic [31:0] POLY32 = 32'h04c1_1db7;
   localparam logic [15:0] POLY16 = 16'h1021;
   localparam logic [31:0] PRESET_ONES = 32'hffff_ffff;
   localparam logic [31:0] PRESET_ZEROS = 32'h0000_0000;

   // flash sector geometry: 1024-byte sectors
   localparam int SECTOR_BYTES = 1024;
   localparam int SECTOR_SHIFT = $clog2(SECTOR_BYTES);
   localparam int FLASH_AW = 17;
   localparam logic [SECTOR_SHIFT-1:0] SECTOR_LAST_OFS = 10'h3ff;
   localparam logic [SECTOR_SHIFT-1:0] SECTOR_FIRST_OFS = 10'h000;

   ////////////////////////////////////////////////////////////////////////////
   // carried field groups
   typedef struct packed {
      logic poly_sel;
      logic preset_val;
      logic [1:0] ptr;
   } crcfs_ctrl_t;

   typedef struct packed {
      logic enable;
      logic done;
      logic [5:0] start_sector;
   } crcfs_auto_t;

   typedef enum logic [1:0] {
      SCAN_IDLE,
      SCAN_REQ,
      SCAN_FOLD
   } crcfs_scan_t;

endpackage : crcfs_pkg

// ==== sim/crcfs_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module crcfs_flash_model (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // flash read port
   input wire logic [crcfs_pkg::FLASH_AW-1:0] flash_addr_q,
   input wire logic flash_rd_q,
   output logic [7:0] flash_rdata
);
   // data valid only in the cycle after a request, toggling garbage otherwise
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         flash_rdata <= 8'h00;
      else if (flash_rd_q)
         flash_rdata <= flash_addr_q[7:0] ^ {flash_addr_q[12:8], 3'b101};
      else
         flash_rdata <= ~flash_rdata;
   end
endmodule : crcfs_flash_model

`default_nettype wire

// ==== sim/crcfs_engine_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module crcfs_engine_tb_top;
   logic clock, arst_n, sfr_wr, sfr_rd, flash_rd_q, cpu_stall_q, p16;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, flash_rdata, rv, ctlv;
   logic [crcfs_pkg::FLASH_AW-1:0] flash_addr_q, next_addr;
   logic [31:0] crc;
   logic [1:0] ptr;
   int failures, num_checks, cycles, nbytes, addr_err, stall_cyc;

   // device and flash behind it
   crcfs_engine uut (.clock(clock), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
      .flash_addr_q(flash_addr_q), .flash_rd_q(flash_rd_q), .flash_rdata(flash_rdata),
      .cpu_stall_q(cpu_stall_q));
   crcfs_flash_model flash (.clock(clock), .arst_n(arst_n), .flash_addr_q(flash_addr_q),
      .flash_rd_q(flash_rd_q), .flash_rdata(flash_rdata));

   // 50 ns clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////
   // msb-first fold; 16-bit crc kept in the upper half while shifting
   function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] d, logic m16);
      logic [31:0] r;
      logic [31:0] p;
      p = m16 ? {crcfs_pkg::POLY16, 16'h0000} : crcfs_pkg::POLY32;
      r = m16 ? {c[15:0] ^ {d, 8'h00}, 16'h0000} : c ^ {d, 24'h00_0000};
      for (int i = 0; i < 8; i++)
         r = r[31] ? ((r << 1) ^ p) : (r << 1);
      return m16 ? {16'h0000, r[31:16]} : r;
   endfunction : fold

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // one-cycle register bus cycles
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      #1;
      v = sfr_rdata_q;
   endtask : rd

   task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
      rd(a, rv);
      check(rv, exp);
   endtask : rd_chk

   // control write and its effect on the expected result
   task automatic ctl(logic [7:0] v);
      wr(crcfs_pkg::ADDR_CONTROL, v);
      ctlv = v;
      ptr = v[1:0];
      p16 = v[4];
      if (v[3])
         crc = v[2] ? crcfs_pkg::PRESET_ONES : crcfs_pkg::PRESET_ZEROS;
   endtask : ctl

   task automatic din(logic [7:0] d);
      wr(crcfs_pkg::ADDR_DATA_IN, d);
      crc = fold(crc, d, p16);
   endtask : din

   task automatic wres(logic [7:0] d);
      wr(crcfs_pkg::ADDR_RESULT, d);
      crc[8*ptr +: 8] = d;
      ptr++;
   endtask : wres

   // four result reads walking the pointer, then the pointer readback
   task automatic chk_result();
      for (int i = 0; i < 4; i++)
      begin
         rd(crcfs_pkg::ADDR_RESULT, rv);
         check(rv, crc[8*(p16 ? {1'b0, ptr[0]} : ptr) +: 8]);
         ptr++;
      end
      rd_chk(crcfs_pkg::ADDR_CONTROL, {3'b000, ctlv[4], 1'b0, ctlv[2], ptr});
   endtask : chk_result

   ////////////////////////////////////////////////////////////////////////////
   // scan monitor, stall length and run ceiling
   always @(posedge clock)
   begin
      cycles++;
      if (flash_rd_q === 1'b1)
      begin
         if (flash_addr_q !== next_addr)
            addr_err++;
         crc = fold(crc, flash_addr_q[7:0] ^ {flash_addr_q[12:8], 3'b101}, p16);
         next_addr++;
         nbytes++;
      end
      if (cpu_stall_q === 1'b1)
         stall_cyc++;
      if (cycles == 20000)
      begin
         failures++;
         finish_test();
      end
   end

   // main sequence
   initial
   begin
      {arst_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
      {crc, ptr, p16, ctlv} = '0;
      next_addr = 17'h0_0800;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      chk_result();
      rd_chk(crcfs_pkg::ADDR_DATA_IN, 8'h00);
      rd_chk(crcfs_pkg::ADDR_FLIP, 8'h00);
      rd_chk(crcfs_pkg::ADDR_AUTO, 8'h40);
      rd_chk(crcfs_pkg::ADDR_COUNT, 8'h00);
      rd_chk(8'h94, 8'h00);
      ctl(8'h0C);
      chk_result();
      ctl(8'h08);
      chk_result();
      ctl(8'h0C);
      din(8'h31);
      din(8'h00);
      din(8'hFF);
      chk_result();
      ctl(8'h1C);
      din(8'hA5);
      din(8'h5A);
      chk_result();
      ctl(8'h06);
      wres(8'hC3);
      wres(8'h3C);
      chk_result();
      wr(crcfs_pkg::ADDR_FLIP, 8'hC0);
      rd_chk(crcfs_pkg::ADDR_FLIP, 8'h03);
      wr(crcfs_pkg::ADDR_FLIP, 8'h05);
      rd_chk(crcfs_pkg::ADDR_FLIP, 8'hA0);
      wr(crcfs_pkg::ADDR_COUNT, 8'hFF);
      rd_chk(crcfs_pkg::ADDR_COUNT, 8'h3F);
      // two-sector scan from sector 2, with an access refused meanwhile
      wr(crcfs_pkg::ADDR_COUNT, 8'h01);
      wr(crcfs_pkg::ADDR_AUTO, 8'h82);
      rd_chk(crcfs_pkg::ADDR_AUTO, 8'hC2);
      {nbytes, addr_err, stall_cyc} = '0;
      ctl(8'h0C);
      #1;
      check(cpu_stall_q, 1'b1);
      // harmless follow-up access right after the launching write
      wr(crcfs_pkg::ADDR_DATA_IN, 8'h77);
      for (int i = 0; i < 6000 && cpu_stall_q !== 1'b0; i++)
         @(posedge clock);
      check(nbytes, 2048);
      check(next_addr, 17'h0_1000);
      check(addr_err, 0);
      check(stall_cyc, 4096);
      rd_chk(crcfs_pkg::ADDR_AUTO, 8'hC2);
      chk_result();
      finish_test();
   end
endmodule : crcfs_engine_tb_top

`default_nettype wire
